// ==== pin_sync.sv ====
// two-flop synchroniser for the warm reset and subset reset pins
// assumes both pins are asynchronous levels from the reset agent
`timescale 1ns/1ps
module pin_sync
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] pin_sync_q
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pin_sync_q = st_q.s2;
endmodule

// ==== reset_agent_model.sv ====
// far side stand-in: reset agent pins, target packet, strand park state
// assumes bench commands are one-cycle pulses changed at the falling edge
`timescale 1ns/1ps
module reset_agent_model
(
    input  wire logic        clk,
    input  wire logic        go_warm,
    input  wire logic        go_subset,
    input  wire logic        use_pkt,
    input  wire logic [63:0] tgt,
    input  wire logic [7:0]  run_cmd,
    output logic             warm_pin,
    output logic             subset_pin,
    output logic             pkt_valid,
    output logic [63:0]      pkt_mask,
    output logic [7:0]       running
);
    logic [3:0]  cnt_w_q = 4'h0;
    logic [3:0]  cnt_s_q = 4'h0;
    logic        pv_q    = 1'b0;
    logic [63:0] pm_q    = 64'h0;
    logic [7:0]  run_q   = 8'h00;
    always @(posedge clk)
    begin
        cnt_w_q <= go_warm ? 4'h6 : (cnt_w_q != 4'h0 ? cnt_w_q - 4'h1 : 4'h0);
        if (go_subset)
        begin
            cnt_s_q <= 4'hC;
            pv_q    <= use_pkt;
            pm_q    <= tgt;
        end
        else if (cnt_s_q != 4'h0)
        begin
            cnt_s_q <= cnt_s_q - 4'h1;
        end
        else
        begin
            // released packet lines toggle so stale targets never look valid
            pv_q <= 1'b0;
            pm_q <= ~pm_q;
        end
        // parking lags the command by a cycle
        run_q <= run_cmd;
    end
    assign warm_pin   = cnt_w_q != 4'h0;
    assign subset_pin = cnt_s_q > 4'h6;
    assign pkt_valid  = pv_q;
    assign pkt_mask   = pm_q;
    assign running    = run_q;
endmodule

// ==== reset_steer_pkg.sv ====
// constants, register map and helpers shared by the reset steering block
// assumes one processor clock and a fixed count of implemented strands
package reset_steer_pkg;
    localparam int          NUM_STRANDS    = 8;
    localparam int          REG_W          = 64;
    localparam logic [7:0]  SHARED_SPACE   = 8'h41;
    localparam logic [7:0]  VA_TARGET_MASK = 8'h30;
    localparam logic [7:0]  VA_RUN_CTRL    = 8'h50;
    localparam logic [7:0]  VA_RUN_STATUS  = 8'h58;
    // mask bits built read-only; these mirror the available strands
    localparam logic [NUM_STRANDS-1:0] MASK_RO_BITS = 8'h00;
    localparam logic [NUM_STRANDS-1:0] ALL_STRANDS  = 8'hFF;
    localparam logic [NUM_STRANDS-1:0] NO_STRANDS   = 8'h00;

    // lowest set bit only; empty input gives strand 0 so one strand runs
    function automatic logic [NUM_STRANDS-1:0] boot_master(
        input logic [NUM_STRANDS-1:0] en
    );
        logic [NUM_STRANDS-1:0] r;
        r = NO_STRANDS;
        for (int i = NUM_STRANDS - 1; i >= 0; i--)
        begin
            if (en[i])
            begin
                r = NO_STRANDS;
                r[i] = 1'b1;
            end
        end
        if (r == NO_STRANDS)
        begin
            r[0] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [REG_W-1:0] widen(input logic [NUM_STRANDS-1:0] v);
        return {{(REG_W-NUM_STRANDS){1'b0}}, v};
    endfunction
endpackage

// ==== strand_reset_steering.sv ====
// reset steering for all strands of one processor, with its shared registers
// assumes strand inputs and config straps on clk, reset pins asynchronous
`timescale 1ns/1ps
// What this block does
// - strand self resets stay on that strand
// - cold and warm resets hit every strand
// - full reset parks all but boot master
// - subset reset targets any strand set
// - target set may arrive with request
// - otherwise targets come from shared mask
// - steering registers live in space 41
// - one shared mask, bit n strand n
// - mask one resets, mask zero untouched
// - parked strand keeps reset until unparked or a warm reset clears it
// - read-only bits ignore writes, mirror available
// - cold loads available, warm loads enabled
// - writing zero run bit parks strand; all-zero write dropped
module strand_reset_steering
(
    input  wire logic                                    clk,
    input  wire logic                                    rst_n,
    input  wire logic                                    warm_reset_pin,
    input  wire logic                                    subset_reset_pin,
    input  wire logic                                    subset_pkt_valid,
    input  wire logic [reset_steer_pkg::REG_W-1:0]       subset_pkt_mask,
    input  wire logic [reset_steer_pkg::NUM_STRANDS-1:0] software_initiated_reset,
    input  wire logic [reset_steer_pkg::NUM_STRANDS-1:0] timeout_strand_reset,
    input  wire logic [reset_steer_pkg::NUM_STRANDS-1:0] available_mask,
    input  wire logic [reset_steer_pkg::NUM_STRANDS-1:0] enabled_mask,
    input  wire logic [reset_steer_pkg::NUM_STRANDS-1:0] strand_running_status,
    input  wire logic [7:0]                              cfg_space,
    input  wire logic [7:0]                              cfg_va,
    input  wire logic                                    cfg_wr,
    input  wire logic                                    cfg_rd,
    input  wire logic [reset_steer_pkg::REG_W-1:0]       cfg_wdata,
    output logic      [reset_steer_pkg::REG_W-1:0]       cfg_rdata_q,
    output logic                                         cfg_ack_q,
    output logic      [reset_steer_pkg::NUM_STRANDS-1:0] strand_run_q,
    output logic      [reset_steer_pkg::NUM_STRANDS-1:0] strand_local_reset_q,
    output logic      [reset_steer_pkg::NUM_STRANDS-1:0] strand_global_reset_q,
    output logic      [reset_steer_pkg::NUM_STRANDS-1:0] strand_subset_reset_q
);
    localparam int N = reset_steer_pkg::NUM_STRANDS;

    // read-only bits take the second operand; all bits writable today
    function automatic logic [N-1:0] merge_ro(
        input logic [N-1:0] rw_bits,
        input logic [N-1:0] ro_src
    );
        return (rw_bits & ~reset_steer_pkg::MASK_RO_BITS)
             | (ro_src & reset_steer_pkg::MASK_RO_BITS);
    endfunction

    typedef struct packed {
        logic [N-1:0]                        run;
        logic [N-1:0]                        mask;
        logic [N-1:0]                        loc;
        logic [N-1:0]                        glob;
        logic [N-1:0]                        subset;
        logic                                warm_prev;
        logic                                xs_prev;
        logic [reset_steer_pkg::REG_W-1:0]   rdata;
        logic                                ack;
    } steer_s;

    steer_s       st_q;
    steer_s       st_d;
    logic [1:0]   pins_s;
    logic         warm_s;
    logic         xs_s;
    logic         warm_rise;
    logic         xs_rise;
    logic         hit;
    logic [N-1:0] run_wr;
    logic [N-1:0] mask_rd;
    logic [N-1:0] targets;

    pin_sync i_pin_sync
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .pin_in     ({subset_reset_pin, warm_reset_pin}),
        .pin_sync_q (pins_s)
    );

    assign warm_s    = pins_s[0];
    assign xs_s      = pins_s[1];
    assign warm_rise = warm_s & ~st_q.warm_prev;
    assign xs_rise   = xs_s & ~st_q.xs_prev;

    always_comb
    begin
        // only one space decodes; no other steering register exists
        hit     = cfg_space == reset_steer_pkg::SHARED_SPACE;
        run_wr  = cfg_wdata[N-1:0] & enabled_mask;
        mask_rd = merge_ro(st_q.mask, available_mask);
        // packet targets win when supplied; upper packet bits name no strand
        targets = subset_pkt_valid ? subset_pkt_mask[N-1:0] : st_q.mask;
        targets = targets & available_mask;

        st_d           = st_q;
        st_d.warm_prev = warm_s;
        st_d.xs_prev   = xs_s;
        st_d.loc       = software_initiated_reset | timeout_strand_reset;
        st_d.glob      = reset_steer_pkg::NO_STRANDS;
        st_d.subset    = reset_steer_pkg::NO_STRANDS;
        st_d.ack       = 1'b0;

        if (hit && cfg_wr)
        begin
            if (cfg_va == reset_steer_pkg::VA_TARGET_MASK)
            begin
                st_d.mask = merge_ro(cfg_wdata[N-1:0], st_q.mask);
            end
            // parking every enabled strand would strand the chip: dropped
            if (cfg_va == reset_steer_pkg::VA_RUN_CTRL && run_wr != '0)
            begin
                st_d.run = run_wr;
            end
        end

        if (hit && (cfg_wr || cfg_rd))
        begin
            st_d.ack   = 1'b1;
            st_d.rdata = '0;
            if (cfg_rd)
            begin
                unique case (cfg_va)
                    reset_steer_pkg::VA_TARGET_MASK:
                        st_d.rdata = reset_steer_pkg::widen(mask_rd);
                    reset_steer_pkg::VA_RUN_CTRL:
                        st_d.rdata = reset_steer_pkg::widen(st_q.run);
                    reset_steer_pkg::VA_RUN_STATUS:
                        st_d.rdata = reset_steer_pkg::widen(strand_running_status
                                                            & enabled_mask);
                    default:
                        st_d.rdata = '0;
                endcase
            end
        end

        if (xs_rise)
        begin
            st_d.subset = targets;
        end

        // warm reset overrides mask and run writes and subset resets arriving in the same cycle
        if (warm_rise)
        begin
            st_d.glob   = reset_steer_pkg::ALL_STRANDS;
            st_d.run    = reset_steer_pkg::boot_master(enabled_mask);
            st_d.mask   = enabled_mask;
            st_d.subset = reset_steer_pkg::NO_STRANDS;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // cold start: straps are same-clock levels, sampled synchronously
            st_q       <= '0;
            st_q.glob  <= reset_steer_pkg::ALL_STRANDS;
            st_q.run   <= reset_steer_pkg::boot_master(enabled_mask);
            st_q.mask  <= available_mask;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    subset_pending i_subset_pending
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .clear   (|st_q.glob),
        .req     (st_q.subset),
        .running (strand_running_status),
        .fire_q  (strand_subset_reset_q)
    );

    assign cfg_rdata_q           = st_q.rdata;
    assign cfg_ack_q             = st_q.ack;
    assign strand_run_q          = st_q.run;
    assign strand_local_reset_q  = st_q.loc;
    assign strand_global_reset_q = st_q.glob;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    local_only_a: assert property (
        (strand_local_reset_q & ~$past(software_initiated_reset | timeout_strand_reset)) == '0)
        else $error("strand reset leaked to another strand");
    warm_all_a: assert property (
        warm_rise |=> strand_global_reset_q == reset_steer_pkg::ALL_STRANDS)
        else $error("warm reset missed a strand");
    boot_master_a: assert property (
        warm_rise |=> $onehot(strand_run_q) && (strand_run_q & ~$past(enabled_mask)) == '0)
        else $error("boot master not sole runner");
    warm_mask_a: assert property (
        warm_rise |=> st_q.mask == $past(enabled_mask))
        else $error("warm reset mask load wrong");
    mask_target_a: assert property (
        (xs_rise && !warm_rise && !subset_pkt_valid) |=> ##1
        (strand_subset_reset_q & ~$past(st_q.mask, 2)) == '0)
        else $error("subset reset hit unmasked strand");
    pkt_target_a: assert property (
        (xs_rise && !warm_rise && subset_pkt_valid) |=> ##1
        (strand_subset_reset_q & ~$past(subset_pkt_mask[N-1:0], 2)) == '0)
        else $error("packet targets not honoured");
    running_hit_a: assert property (
        (xs_rise && !warm_rise && (targets & strand_running_status) != '0) ##1
        $stable(strand_running_status) |=> strand_subset_reset_q != '0)
        else $error("running target not reset");
    upper_zero_a: assert property (
        cfg_ack_q |-> cfg_rdata_q[reset_steer_pkg::REG_W-1:N] == '0)
        else $error("unimplemented strand bits nonzero");
    ro_mirror_a: assert property (
        (hit && cfg_rd && cfg_va == reset_steer_pkg::VA_TARGET_MASK) |=>
        ((cfg_rdata_q[N-1:0] ^ $past(available_mask)) & reset_steer_pkg::MASK_RO_BITS) == '0)
        else $error("read-only mask bit not mirroring");
    park_write_a: assert property (
        (hit && cfg_wr && cfg_va == reset_steer_pkg::VA_RUN_CTRL && run_wr != '0
        && !warm_rise) |=> strand_run_q == $past(run_wr))
        else $error("run control write not applied");
    space_ack_a: assert property (
        (cfg_wr || cfg_rd) && !hit |=> !cfg_ack_q)
        else $error("foreign space acknowledged");

    local_exact_a: assert property (
        strand_local_reset_q == $past(software_initiated_reset | timeout_strand_reset))
        else $error("strand reset not delivered to its strand");
    glob_level_a: assert property (
        strand_global_reset_q == '0 || strand_global_reset_q == reset_steer_pkg::ALL_STRANDS)
        else $error("global reset reached only some strands");
    glob_pulse_a: assert property (
        strand_global_reset_q != '0 |=> strand_global_reset_q == '0)
        else $error("warm reset pulse too long");

    ack_answer_a: assert property (
        hit && (cfg_wr || cfg_rd) |=> cfg_ack_q)
        else $error("shared space access not acknowledged");
    ack_pulse_a: assert property (
        !(hit && (cfg_wr || cfg_rd)) |=> !cfg_ack_q)
        else $error("acknowledge without access");
    rdata_hold_a: assert property (
        !cfg_ack_q |-> $stable(cfg_rdata_q))
        else $error("read data moved without access");
    unmapped_zero_a: assert property (
        (hit && cfg_rd
        && cfg_va != reset_steer_pkg::VA_TARGET_MASK
        && cfg_va != reset_steer_pkg::VA_RUN_CTRL
        && cfg_va != reset_steer_pkg::VA_RUN_STATUS) |=> cfg_rdata_q == '0)
        else $error("unmapped read not zero");
    status_read_a: assert property (
        (hit && cfg_rd && cfg_va == reset_steer_pkg::VA_RUN_STATUS) |=>
        cfg_rdata_q[N-1:0] == $past(strand_running_status & enabled_mask))
        else $error("run status read wrong");
    run_read_a: assert property (
        (hit && cfg_rd && cfg_va == reset_steer_pkg::VA_RUN_CTRL) |=>
        cfg_rdata_q[N-1:0] == $past(strand_run_q))
        else $error("run control read wrong");
    mask_read_a: assert property (
        (hit && cfg_rd && cfg_va == reset_steer_pkg::VA_TARGET_MASK) |=>
        ((cfg_rdata_q[N-1:0] ^ $past(st_q.mask)) & ~reset_steer_pkg::MASK_RO_BITS) == '0)
        else $error("mask read wrong");

    mask_write_a: assert property (
        (hit && cfg_wr && cfg_va == reset_steer_pkg::VA_TARGET_MASK && !warm_rise) |=>
        ((st_q.mask ^ $past(cfg_wdata[N-1:0])) & ~reset_steer_pkg::MASK_RO_BITS) == '0)
        else $error("mask write not applied");
    ro_write_a: assert property (
        (hit && cfg_wr && cfg_va == reset_steer_pkg::VA_TARGET_MASK && !warm_rise) |=>
        ((st_q.mask ^ $past(st_q.mask)) & reset_steer_pkg::MASK_RO_BITS) == '0)
        else $error("read-only mask bit took a write");
    park_drop_a: assert property (
        (hit && cfg_wr && cfg_va == reset_steer_pkg::VA_RUN_CTRL && run_wr == '0
        && !warm_rise) |=> $stable(strand_run_q))
        else $error("write parking every strand applied");
    run_alive_a: assert property (
        enabled_mask == '0 || (strand_run_q & enabled_mask) != '0)
        else $error("no enabled strand left running");

    avail_only_a: assert property (
        (strand_subset_reset_q & ~available_mask) == '0)
        else $error("subset reset on missing strand");
    warm_clear_a: assert property (
        warm_rise |=> st_q.subset == '0)
        else $error("subset reset survived warm reset");
    sample_targets_a: assert property (
        xs_rise && !warm_rise |=> st_q.subset == $past(available_mask
            & (subset_pkt_valid ? subset_pkt_mask[N-1:0] : st_q.mask)))
        else $error("subset targets not sampled at edge");
    subset_idle_a: assert property (
        !xs_rise || warm_rise |=> st_q.subset == '0)
        else $error("subset reset without an edge");

    warm_cov_c: cover property (warm_rise ##1 strand_global_reset_q != '0);
    mask_cov_c: cover property (xs_rise && !subset_pkt_valid ##2 strand_subset_reset_q != '0);
    pkt_cov_c:  cover property (xs_rise && subset_pkt_valid ##2 strand_subset_reset_q != '0);
    park_cov_c: cover property (hit && cfg_wr && cfg_va == reset_steer_pkg::VA_RUN_CTRL);
endmodule

// ==== subset_pending.sv ====
// holds subset resets for parked strands until they run again or clear drops them
// assumes run status comes from strand logic on the same clock
`timescale 1ns/1ps
module subset_pending
(
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    input  wire logic                                  clear,
    input  wire logic [reset_steer_pkg::NUM_STRANDS-1:0] req,
    input  wire logic [reset_steer_pkg::NUM_STRANDS-1:0] running,
    output logic      [reset_steer_pkg::NUM_STRANDS-1:0] fire_q
);
    typedef struct packed {
        logic [reset_steer_pkg::NUM_STRANDS-1:0] pend;
        logic [reset_steer_pkg::NUM_STRANDS-1:0] fire;
    } pend_s;

    pend_s st_q;
    pend_s st_d;
    logic [reset_steer_pkg::NUM_STRANDS-1:0] want;

    always_comb
    begin
        // new request beats a global clear in the same cycle
        want      = (st_q.pend & ~{reset_steer_pkg::NUM_STRANDS{clear}}) | req;
        st_d      = st_q;
        st_d.fire = want & running;
        st_d.pend = want & ~running;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign fire_q = st_q.fire;

    parked_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req & ~running) != '0 |=> (fire_q & $past(req & ~running)) == '0)
        else $error("parked strand got subset reset");
    late_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q.pend & running) != '0 |=> (fire_q & $past(st_q.pend & running)) != '0)
        else $error("pending reset not taken on unpark");
    pend_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
        st_q.pend != '0 ##[1:20] fire_q != '0);
endmodule

// ==== testbench.sv ====
// self-checking bench for the reset steering block
// assumes the agent model on the far side; strand straps held static
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] AVAIL = 8'h7E;
    localparam logic [7:0] ENAB  = 8'h3C;
    logic clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic go_warm = 1'b0, go_subset = 1'b0, use_pkt = 1'b0;
    logic [7:0]  cfg_space = 8'h00, cfg_va = 8'h00, sw_rst = 8'h00, to_rst = 8'h00;
    logic [7:0]  seen = 8'h00;
    logic [63:0] cfg_wdata = 64'h0, tgt = 64'h0, rdat;
    logic [63:0] cfg_rdata_q;
    logic        cfg_ack_q, ack, warm_pin, subset_pin, pkt_valid;
    logic [63:0] pkt_mask;
    logic [7:0]  running, run_q, loc_q, glob_q, sub_q;
    int          n_fail = 0, total_checks = 0, gcnt = 0;
    strand_reset_steering i_strand_reset_steering (.clk(clk), .rst_n(rst_n),
        .warm_reset_pin(warm_pin), .subset_reset_pin(subset_pin),
        .subset_pkt_valid(pkt_valid), .subset_pkt_mask(pkt_mask),
        .software_initiated_reset(sw_rst), .timeout_strand_reset(to_rst),
        .available_mask(AVAIL), .enabled_mask(ENAB), .strand_running_status(running),
        .cfg_space(cfg_space), .cfg_va(cfg_va), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_ack_q(cfg_ack_q),
        .strand_run_q(run_q), .strand_local_reset_q(loc_q),
        .strand_global_reset_q(glob_q), .strand_subset_reset_q(sub_q));
    reset_agent_model i_reset_agent_model (.clk(clk), .go_warm(go_warm),
        .go_subset(go_subset), .use_pkt(use_pkt), .tgt(tgt), .run_cmd(run_q),
        .warm_pin(warm_pin), .subset_pin(subset_pin), .pkt_valid(pkt_valid),
        .pkt_mask(pkt_mask), .running(running));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] sp, input logic [7:0] va,
                       input logic [63:0] wd);
        @(negedge clk);
        cfg_wr = wr;
        cfg_rd = !wr;
        cfg_space = sp;
        cfg_va = va;
        cfg_wdata = wd;
        @(negedge clk);
        rdat = cfg_rdata_q;
        ack = cfg_ack_q;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
    endtask
    task automatic wr(input logic [7:0] va, input logic [63:0] wd);
        acc(1'b1, reset_steer_pkg::SHARED_SPACE, va, wd);
        chk({63'h0, ack}, 64'h1);
    endtask
    task automatic rd(input logic [7:0] va, input logic [63:0] exp);
        acc(1'b0, reset_steer_pkg::SHARED_SPACE, va, 64'h0);
        chk({63'h0, ack}, 64'h1);
        chk(rdat, exp);
    endtask
    task automatic fire(input logic pkt, input logic [63:0] t);
        @(negedge clk);
        go_subset = 1'b1;
        use_pkt = pkt;
        tgt = t;
        seen = 8'h00;
        @(negedge clk);
        go_subset = 1'b0;
        repeat (14)
        begin
            @(negedge clk);
            seen = seen | sub_q;
        end
    endtask
    task automatic t_local;
        @(negedge clk);
        sw_rst = 8'h04;
        to_rst = 8'h20;
        @(negedge clk);
        chk(loc_q, 8'h24);
        chk(glob_q | sub_q, 8'h00);
        sw_rst = 8'h00;
        to_rst = 8'h00;
        @(negedge clk);
        chk(loc_q, 8'h00);
    endtask
    task automatic t_regs;
        rd(reset_steer_pkg::VA_TARGET_MASK, 64'h7E);
        wr(reset_steer_pkg::VA_TARGET_MASK, 64'hFFFF_FFFF_FFFF_FF8C);
        rd(reset_steer_pkg::VA_TARGET_MASK, 64'h8C);
        rd(8'h10, 64'h0);
        rd(reset_steer_pkg::VA_RUN_STATUS, 64'h04);
        acc(1'b0, 8'h40, reset_steer_pkg::VA_TARGET_MASK, 64'h0);
        chk({63'h0, ack}, 64'h0);
    endtask
    task automatic t_mask_steer;
        wr(reset_steer_pkg::VA_RUN_CTRL, 64'h3C);
        rd(reset_steer_pkg::VA_RUN_STATUS, 64'h3C);
        fire(1'b0, 64'h0);
        chk(seen, 8'h0C);
    endtask
    task automatic t_packet;
        fire(1'b1, 64'hFF00_0000_0000_0030);
        chk(seen, 8'h30);
        fire(1'b1, 64'h0);
        chk(seen, 8'h00);
    endtask
    task automatic t_parked;
        wr(reset_steer_pkg::VA_RUN_CTRL, 64'h00);
        rd(reset_steer_pkg::VA_RUN_CTRL, 64'h3C);
        wr(reset_steer_pkg::VA_RUN_CTRL, 64'h2C);
        rd(reset_steer_pkg::VA_RUN_CTRL, 64'h2C);
        wr(reset_steer_pkg::VA_TARGET_MASK, 64'h10);
        fire(1'b0, 64'h0);
        chk(seen, 8'h00);
        wr(reset_steer_pkg::VA_RUN_CTRL, 64'h3C);
        repeat (6)
        begin
            @(negedge clk);
            seen = seen | sub_q;
        end
        chk(seen, 8'h10);
    endtask
    task automatic t_warm;
        @(negedge clk);
        go_warm = 1'b1;
        gcnt = 0;
        @(negedge clk);
        go_warm = 1'b0;
        repeat (10)
        begin
            @(negedge clk);
            gcnt = gcnt + ((glob_q === 8'hFF) ? 1 : 0);
        end
        chk(64'(gcnt), 64'h1);
        chk(run_q, 8'h04);
        rd(reset_steer_pkg::VA_TARGET_MASK, 64'h3C);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && total_checks > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial
    begin
        // the whole run is about 120 cycles
        #40000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(negedge clk);
        chk(glob_q, 8'hFF);
        chk(run_q, 8'h04);
        rst_n = 1'b1;
        t_local();
        t_regs();
        t_mask_steer();
        t_packet();
        t_parked();
        t_warm();
        tally_and_finish();
    end
endmodule
